// [logic/shic_standby_ctrl.sv]
// Halt and light idle standby controller with wake acknowledge decisions
// Notes on behaviour
// - Any NMI or unmasked request ends halt
// - Non-nested NMI wake is acknowledged at once
// - Interrupts disabled: leave halt, keep request pending
// - Higher priority service active: keep request pending
// - Lower priority service active: acknowledge wake request
// - Halt: general timer runs unless subclock-sourced
// - Halt: watch timer runs on baud divider
// - Halt: watchdog runs unless internal oscillator
// - Halt: checksum runs only without input write
// - Halt holds pins, registers; peripherals keep running
// - Mode bits 00 plus trigger enters light idle
// - Light idle: oscillator, PLL, flash on; CPU, peripherals off
// - Light idle: subclock peripherals run, program stops
// - Idle exit inserts no stabilization wait
// - Pending unmasked request refuses light idle entry
// - Idle ends on NMI, edges, running peripherals
// - Idle ends on any reset source
// - Idle release returns to normal mode
// - Halt instruction stops the CPU clock; peripheral and oscillator clocks stay on
// - Halt with pending request exits at once
// - Halt ends on same sources, returns normal
// - Idle wake acknowledge follows halt conditions
module shic_standby_ctrl
  import shic_pkg::*;
#(
  parameter int NUM_PERIPH = 16,
  parameter int PRIO_W = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic halt_exec,
  input wire logic mode_select_hi,
  input wire logic mode_select_lo,
  input wire logic standby_trigger,
  input wire logic nmi_pin,
  input wire logic watchdog_nonmaskable_req,
  input wire logic nmi_in_service,
  input wire logic [EXT_IRQ_COUNT-1:0] external_irq_pins,
  input wire logic [EXT_IRQ_COUNT-1:0] ext_irq_mask,
  input wire logic [NUM_PERIPH-1:0] periph_irq_req,
  input wire logic [NUM_PERIPH-1:0] periph_irq_mask,
  input wire logic [NUM_PERIPH-1:0] periph_runs_in_idle,
  input wire logic maskable_pending,
  input wire logic [PRIO_W-1:0] wake_prio,
  input wire logic irq_globally_enabled,
  input wire logic svc_active,
  input wire logic [PRIO_W-1:0] svc_prio,
  input wire logic reset_pin_req,
  input wire logic watchdog_reset_out,
  input wire logic low_voltage_detector,
  input wire logic clock_monitor,
  input wire logic subclock_used,
  input wire logic timer_src_subclock,
  input wire logic watch_src_baud_divider,
  input wire logic wdt_src_internal_osc,
  input wire logic checksum_write_busy,
  output logic in_halt_q,
  output logic in_idle_q,
  output logic cpu_clk_en_q,
  output logic periph_clk_en_q,
  output logic osc_pll_flash_run_q,
  output logic general_timer_clk_en_q,
  output logic watch_timer_clk_en_q,
  output logic watchdog_clk_en_q,
  output logic checksum_clk_en_q,
  output logic state_hold_q,
  output logic ack_nmi_q,
  output logic ack_maskable_q,
  output logic hold_pending_q,
  output logic sys_reset_req_q,
  output logic idle_refused_q
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_PERIPH < 1 || PRIO_W < 1) begin : g_bad_param
    $error("NUM_PERIPH and PRIO_W must be at least one");
  end

  // ----------------------------------------------------------------
  // Wake source decode
  // ----------------------------------------------------------------
  shic_state_t state_q, state_d;
  logic [EXT_IRQ_COUNT-1:0] ext_pins_q, ext_pins_d;
  logic [NUM_PERIPH-1:0] periph_live;
  logic [EXT_IRQ_COUNT-1:0] ext_edge;
  logic nmi_req, any_reset, mask_wake, sleeping, idle_req;
  logic in_halt_d, in_idle_d, cpu_clk_en_d, periph_clk_en_d, osc_run_d;
  logic gtimer_d, watch_d, wdog_d, crc_d, hold_d;
  logic ack_nmi_d, ack_mask_d, hold_pend_d, sys_rst_d, refused_d;

  // Edges only count once unmasked; a level held high does not rewake
  assign ext_edge = external_irq_pins & ~ext_pins_q & ~ext_irq_mask;
  assign nmi_req = nmi_pin | watchdog_nonmaskable_req;
  assign any_reset = reset_pin_req | watchdog_reset_out
                   | low_voltage_detector | clock_monitor;
  // In idle only peripherals that still have a clock can wake us
  assign periph_live = periph_irq_req & ~periph_irq_mask
                     & ((state_q == SHIC_IDLE) ? periph_runs_in_idle : '1);
  assign mask_wake = maskable_pending | (|ext_edge) | (|periph_live);
  assign sleeping = (state_q != SHIC_NORMAL);
  assign idle_req = standby_trigger == STANDBY_TRIGGER_SET
                  && {mode_select_hi, mode_select_lo} == MODE_SEL_LIGHT_IDLE;

  // ----------------------------------------------------------------
  // State and wake decision
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ack_nmi_d = RST_PULSE;
    ack_mask_d = RST_PULSE;
    hold_pend_d = RST_PULSE;
    sys_rst_d = RST_PULSE;
    refused_d = RST_PULSE;
    unique case (state_q)
      SHIC_NORMAL: begin
        if (halt_exec) begin
          // Entered even with a request pending; it wakes us next cycle
          state_d = SHIC_HALT;
        end else if (idle_req) begin
          if (maskable_pending || nmi_req) begin
            refused_d = 1'b1;
          end else begin
            state_d = SHIC_IDLE;
          end
        end
      end
      SHIC_HALT, SHIC_IDLE: begin
        // Reset beats NMI beats maskable; all return to normal mode
        if (any_reset) begin
          state_d = SHIC_NORMAL;
          sys_rst_d = 1'b1;
        end else if (nmi_req) begin
          state_d = SHIC_NORMAL;
          // Nested NMI cannot be taken again until the first returns
          ack_nmi_d = !nmi_in_service;
          hold_pend_d = nmi_in_service;
        end else if (mask_wake) begin
          state_d = SHIC_NORMAL;
          if (!irq_globally_enabled) begin
            hold_pend_d = 1'b1;
          end else if (svc_active && svc_prio <= wake_prio) begin
            // Smaller priority value means more urgent
            hold_pend_d = 1'b1;
          end else begin
            ack_mask_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = SHIC_NORMAL;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Clock gating derived from the next state
  // ----------------------------------------------------------------
  always_comb begin
    in_halt_d = (state_d == SHIC_HALT);
    in_idle_d = (state_d == SHIC_IDLE);
    ext_pins_d = external_irq_pins;
    // Oscillator, PLL and flash never stop here, so wake needs no wait
    osc_run_d = 1'b1;
    cpu_clk_en_d = (state_d == SHIC_NORMAL);
    periph_clk_en_d = !in_idle_d;
    hold_d = in_halt_d || in_idle_d;
    gtimer_d = 1'b1;
    watch_d = 1'b1;
    wdog_d = 1'b1;
    crc_d = 1'b1;
    if (in_halt_d) begin
      gtimer_d = subclock_used || !timer_src_subclock;
      watch_d = subclock_used || watch_src_baud_divider;
      wdog_d = subclock_used || !wdt_src_internal_osc;
      // A write into the checksum input would stall the stopped CPU
      crc_d = !checksum_write_busy;
    end else if (in_idle_d) begin
      // Only subclock-fed units keep counting in light idle
      gtimer_d = subclock_used && timer_src_subclock;
      watch_d = subclock_used && !watch_src_baud_divider;
      wdog_d = subclock_used && !wdt_src_internal_osc;
      crc_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers; clk_en low freezes every flop
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= SHIC_NORMAL;
      ext_pins_q <= '0;
      in_halt_q <= RST_HOLD;
      in_idle_q <= RST_HOLD;
      cpu_clk_en_q <= RST_CPU_CLK_EN;
      periph_clk_en_q <= RST_PERIPH_CLK_EN;
      osc_pll_flash_run_q <= RST_OSC_RUN;
      general_timer_clk_en_q <= RST_PERIPH_CLK_EN;
      watch_timer_clk_en_q <= RST_PERIPH_CLK_EN;
      watchdog_clk_en_q <= RST_PERIPH_CLK_EN;
      checksum_clk_en_q <= RST_PERIPH_CLK_EN;
      state_hold_q <= RST_HOLD;
      ack_nmi_q <= RST_PULSE;
      ack_maskable_q <= RST_PULSE;
      hold_pending_q <= RST_PULSE;
      sys_reset_req_q <= RST_PULSE;
      idle_refused_q <= RST_PULSE;
    end else if (clk_en) begin
      state_q <= state_d;
      ext_pins_q <= ext_pins_d;
      in_halt_q <= in_halt_d;
      in_idle_q <= in_idle_d;
      cpu_clk_en_q <= cpu_clk_en_d;
      periph_clk_en_q <= periph_clk_en_d;
      osc_pll_flash_run_q <= osc_run_d;
      general_timer_clk_en_q <= gtimer_d;
      watch_timer_clk_en_q <= watch_d;
      watchdog_clk_en_q <= wdog_d;
      checksum_clk_en_q <= crc_d;
      state_hold_q <= hold_d;
      ack_nmi_q <= ack_nmi_d;
      ack_maskable_q <= ack_mask_d;
      hold_pending_q <= hold_pend_d;
      sys_reset_req_q <= sys_rst_d;
      idle_refused_q <= refused_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic woke_by_mask;
  assign woke_by_mask = clk_en && sleeping && !any_reset && !nmi_req && mask_wake;

  sequence s_idle_req;
    clk_en && state_q == SHIC_NORMAL && !halt_exec && idle_req;
  endsequence
  sequence s_sleep_wake;
    clk_en && sleeping && (nmi_req || mask_wake || any_reset);
  endsequence

  property p_wake_exits;
    s_sleep_wake |=> !in_halt_q && !in_idle_q && cpu_clk_en_q;
  endproperty
  a_wake_exits: assert property (p_wake_exits) else $error("sleep not left on wake");

  property p_nmi_ack;
    clk_en && sleeping && !any_reset && nmi_req && !nmi_in_service |=> ack_nmi_q;
  endproperty
  a_nmi_ack: assert property (p_nmi_ack) else $error("nmi wake not acknowledged");

  property p_di_hold;
    woke_by_mask && !irq_globally_enabled |=> hold_pending_q && !ack_maskable_q;
  endproperty
  a_di_hold: assert property (p_di_hold) else $error("disabled wake acknowledged");

  property p_prio_hold;
    woke_by_mask && irq_globally_enabled && svc_active && svc_prio <= wake_prio
      |=> hold_pending_q && !ack_maskable_q;
  endproperty
  a_prio_hold: assert property (p_prio_hold) else $error("lower wake preempted");

  property p_prio_ack;
    woke_by_mask && irq_globally_enabled && !(svc_active && svc_prio <= wake_prio)
      |=> ack_maskable_q && !hold_pending_q;
  endproperty
  a_prio_ack: assert property (p_prio_ack) else $error("urgent wake not taken");

  property p_halt_gtimer;
    in_halt_q && !$past(subclock_used) && $past(timer_src_subclock) && $past(clk_en)
      |-> !general_timer_clk_en_q;
  endproperty
  a_halt_gtimer: assert property (p_halt_gtimer) else $error("timer ran on subclock");

  property p_halt_watch;
    in_halt_q && $past(subclock_used) && $past(clk_en) |-> watch_timer_clk_en_q;
  endproperty
  a_halt_watch: assert property (p_halt_watch) else $error("watch timer stopped");

  property p_halt_wdog;
    in_halt_q && $past(subclock_used) && $past(clk_en) |-> watchdog_clk_en_q;
  endproperty
  a_halt_wdog: assert property (p_halt_wdog) else $error("watchdog stopped");

  property p_halt_crc;
    clk_en && state_d == SHIC_HALT && checksum_write_busy |=> !checksum_clk_en_q;
  endproperty
  a_halt_crc: assert property (p_halt_crc) else $error("checksum ran while written");

  property p_idle_entry;
    s_idle_req ##0 !maskable_pending && !nmi_req |=> in_idle_q && state_hold_q;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

  property p_idle_refuse;
    s_idle_req ##0 (maskable_pending || nmi_req) |=> idle_refused_q && !in_idle_q;
  endproperty
  a_idle_refuse: assert property (p_idle_refuse) else $error("idle entered with pending");

  property p_idle_clocks;
    in_idle_q |-> osc_pll_flash_run_q && !cpu_clk_en_q && !periph_clk_en_q;
  endproperty
  a_idle_clocks: assert property (p_idle_clocks) else $error("idle clocks wrong");

  property p_halt_only_cpu;
    in_halt_q |-> !cpu_clk_en_q && periph_clk_en_q && osc_pll_flash_run_q;
  endproperty
  a_halt_only_cpu: assert property (p_halt_only_cpu) else $error("halt gated too much");

  property p_reset_wake;
    clk_en && sleeping && any_reset |=> sys_reset_req_q && !ack_nmi_q && !ack_maskable_q;
  endproperty
  a_reset_wake: assert property (p_reset_wake) else $error("reset wake lost");

  property p_halt_pending;
    clk_en && state_q == SHIC_NORMAL && halt_exec ##1 clk_en && maskable_pending
      |=> !in_halt_q;
  endproperty
  a_halt_pending: assert property (p_halt_pending) else $error("pending halt stuck");

endmodule

// [common/shic_pkg.sv]
// Shared constants and types for the halt / light idle standby controller
package shic_pkg;

  // ----------------------------------------------------------------
  // Standby states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SHIC_NORMAL = 2'b00,
    SHIC_HALT   = 2'b01,
    SHIC_IDLE   = 2'b10
  } shic_state_t;

  // ----------------------------------------------------------------
  // Mode select and trigger encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_SEL_LIGHT_IDLE = 2'h0;
  localparam logic STANDBY_TRIGGER_SET = 1'h1;
  localparam int EXT_IRQ_COUNT = 8;

  // ----------------------------------------------------------------
  // Reset values of the registered outputs
  // ----------------------------------------------------------------
  localparam logic RST_CPU_CLK_EN = 1'h1;
  localparam logic RST_PERIPH_CLK_EN = 1'h1;
  localparam logic RST_OSC_RUN = 1'h1;
  localparam logic RST_HOLD = 1'h0;
  localparam logic RST_PULSE = 1'h0;

  // ----------------------------------------------------------------
  // Timing: wake to resumed clocks, no stabilization wait
  // ----------------------------------------------------------------
  localparam int WAKE_TO_RUN_CYCLES = 1;
  localparam int OSC_STAB_WAIT_CYCLES = 0;

endpackage

// [testbench/shic_cpu_model.sv]
// CPU core model that issues halt and light idle requests to the standby controller
module shic_cpu_model (
  input wire logic clk,
  output logic halt_exec,
  output logic standby_trigger,
  output logic mode_select_hi,
  output logic mode_select_lo
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc = 0;
  int last_req = -10;
  // Idle at start; mode bits parked away from light idle until the first request
  initial {halt_exec, standby_trigger, mode_select_hi, mode_select_lo} = 4'h3;
  // Cycle count, used only to space requests
  always @(posedge clk) cyc <= cyc + 1;
  // One request for one cycle, launched and ended on falling edges
  task automatic pulse(input logic h, input logic [1:0] m);
    // Software lets six no-ops pass after a trigger write
    while (cyc - last_req < 6) @(negedge clk);
    {mode_select_hi, mode_select_lo} = m;
    halt_exec = h;
    standby_trigger = !h;
    @(negedge clk);
    {halt_exec, standby_trigger} = 2'h0;
    last_req = cyc;
  endtask
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the halt and light idle standby controller
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
module tb_top;
  import shic_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Stimulus and design
  // ----------------------------------------------------------------
  int miscompares = 0;
  int n_checks = 0;
  logic clk = 1'h0, reset = 1'h1, clk_en = 1'h1, nmi_pin = 1'h0, wd_nmi = 1'h0;
  logic ei = 1'h0, svc_active = 1'h0, mpend = 1'h0, sub = 1'h0, tsub = 1'h0, baud = 1'h0;
  logic intosc = 1'h0, ckbusy = 1'h0, nest = 1'h0;
  logic [3:0] rst_src = 4'h0;
  logic [2:0] wake_prio = 3'h0, svc_prio = 3'h0;
  logic [7:0] ext_pins = 8'h00, ext_mask = 8'h00;
  logic [15:0] p_req = 16'h0000, p_run = 16'h0002, p_mask = 16'h0000;
  logic halt_exec, trig, msh, msl, in_halt_q, in_idle_q, cpu_en, per_en, osc, gt_en, wt_en;
  logic wd_en, ck_en, hold_q, ack_nmi, ack_m, pend_q, sys_rst, refused;
  // Forty nanosecond clock
  initial forever #20 clk = !clk;
  shic_cpu_model cpu (.clk(clk), .halt_exec(halt_exec), .standby_trigger(trig),
    .mode_select_hi(msh), .mode_select_lo(msl));
  shic_standby_ctrl uut (.clk(clk), .reset(reset), .clk_en(clk_en), .halt_exec(halt_exec),
    .mode_select_hi(msh), .mode_select_lo(msl), .standby_trigger(trig), .nmi_pin(nmi_pin),
    .watchdog_nonmaskable_req(wd_nmi), .nmi_in_service(nest), .external_irq_pins(ext_pins),
    .ext_irq_mask(ext_mask), .periph_irq_req(p_req), .periph_irq_mask(p_mask),
    .periph_runs_in_idle(p_run), .maskable_pending(mpend), .wake_prio(wake_prio),
    .irq_globally_enabled(ei), .svc_active(svc_active), .svc_prio(svc_prio),
    .reset_pin_req(rst_src[0]), .watchdog_reset_out(rst_src[1]),
    .low_voltage_detector(rst_src[2]), .clock_monitor(rst_src[3]), .subclock_used(sub),
    .timer_src_subclock(tsub), .watch_src_baud_divider(baud), .wdt_src_internal_osc(intosc),
    .checksum_write_busy(ckbusy), .in_halt_q(in_halt_q), .in_idle_q(in_idle_q),
    .cpu_clk_en_q(cpu_en), .periph_clk_en_q(per_en), .osc_pll_flash_run_q(osc),
    .general_timer_clk_en_q(gt_en), .watch_timer_clk_en_q(wt_en), .watchdog_clk_en_q(wd_en),
    .checksum_clk_en_q(ck_en), .state_hold_q(hold_q), .ack_nmi_q(ack_nmi),
    .ack_maskable_q(ack_m), .hold_pending_q(pend_q), .sys_reset_req_q(sys_rst),
    .idle_refused_q(refused));
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Masked edge keeps halt, then a non-maskable source wakes and is taken at once
  task automatic t_nmi();
    cpu.pulse(1'h1, 2'h0);
    `CHK("halt clocks", 4'h7, {cpu_en, per_en, osc, hold_q})
    ext_mask = 8'hFF;
    ext_pins = 8'h01;
    @(negedge clk);
    `CHK("masked edge", 1'h1, in_halt_q)
    {ext_pins, ext_mask, nmi_pin} = 17'h00001;
    @(negedge clk);
    nmi_pin = 1'h0;
    `CHK("halt nmi wake", 4'h5, {in_halt_q, cpu_en, hold_q, ack_nmi})
    cpu.pulse(1'h0, 2'h0);
    wd_nmi = 1'h1;
    @(negedge clk);
    wd_nmi = 1'h0;
    `CHK("idle nmi wake", 4'h7, {in_idle_q, cpu_en, per_en, ack_nmi})
  endtask
  // Unmasked edge wakes; acknowledge or hold follows enable and priority
  task automatic t_wake(input logic idle, input logic e, input logic sa, input logic [2:0] sp,
                        input logic [2:0] wp, input logic ack);
    {ei, svc_active, svc_prio, wake_prio} = {e, sa, sp, wp};
    cpu.pulse(!idle, 2'h0);
    `CHK("asleep", {!idle, idle}, {in_halt_q, in_idle_q})
    ext_pins = 8'h01;
    @(negedge clk);
    ext_pins = 8'h00;
    `CHK("wake ack", {2'h0, ack, !ack}, {in_halt_q, in_idle_q, ack_m, pend_q})
  endtask
  // Timer gating in halt for three clock source settings, then wake by NMI
  task automatic t_halt_gate();
    for (int j = 0; j < 3; j++) begin
      {sub, tsub, baud, intosc, ckbusy} = {j == 2, j > 0, j == 0, j > 0, j > 0};
      cpu.pulse(1'h1, 2'h0);
      `CHK("halt gating", {{3{sub | !tsub}}, !ckbusy}, {gt_en, wt_en, wd_en, ck_en})
      nmi_pin = 1'h1;
      @(negedge clk);
      nmi_pin = 1'h0;
    end
  endtask
  // Light idle gating; only a peripheral clocked in idle may wake it
  task automatic t_idle();
    {sub, tsub, baud, intosc, ei, svc_active} = 6'h32;
    cpu.pulse(1'h0, 2'h0);
    `CHK("idle clocks", 7'h4F, {in_idle_q, cpu_en, per_en, osc, hold_q, gt_en, wt_en})
    `CHK("idle gated", 2'h2, {wd_en, ck_en})
    p_req = 16'h0001;
    @(negedge clk);
    `CHK("stopped periph", 1'h1, in_idle_q)
    p_req = 16'h0002;
    @(negedge clk);
    p_req = 16'h0000;
    `CHK("running periph", 2'h1, {in_idle_q, ack_m})
  endtask
  // Each reset source ends halt or light idle and requests a system reset
  task automatic t_resets();
    for (int k = 0; k < 4; k++) begin
      cpu.pulse(!k[0], 2'h0);
      rst_src[k] = 1'h1;
      @(negedge clk);
      rst_src = 4'h0;
      `CHK("reset wake", 3'h1, {in_halt_q, in_idle_q, sys_rst})
    end
  endtask
  // Masked peripheral keeps halt; clk_en low freezes it; a nested NMI wake is held
  task automatic t_misc();
    {ei, svc_active, p_mask, nest} = {1'h1, 1'h0, 16'h0002, 1'h1};
    cpu.pulse(1'h1, 2'h0);
    p_req = 16'h0002;
    @(negedge clk);
    `CHK("masked periph", 1'h1, in_halt_q)
    {clk_en, p_req, p_mask, nmi_pin} = 34'h000000001;
    @(negedge clk);
    `CHK("frozen halt", 3'h6, {in_halt_q, hold_q, ack_nmi})
    clk_en = 1'h1;
    @(negedge clk);
    {nmi_pin, nest} = 2'h0;
    `CHK("nested nmi", 4'h5, {in_halt_q, cpu_en, ack_nmi, pend_q})
  endtask
  // Other mode bits ignore the trigger; a pending request refuses idle or ends halt
  task automatic t_pending();
    cpu.pulse(1'h0, 2'h1);
    `CHK("mode 01", 2'h0, {in_idle_q, refused})
    mpend = 1'h1;
    cpu.pulse(1'h0, 2'h0);
    `CHK("idle refused", 2'h1, {in_idle_q, refused})
    cpu.pulse(1'h1, 2'h0);
    `CHK("pending halt entry", 1'h1, in_halt_q)
    @(negedge clk);
    mpend = 1'h0;
    `CHK("pending halt exit", 1'h0, in_halt_q)
  endtask
  // ----------------------------------------------------------------
  // Main sequence and verdict
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'h0;
    `CHK("reset state", 5'h07, {in_halt_q, in_idle_q, cpu_en, per_en, osc})
    t_nmi();
    t_wake(1'h0, 1'h0, 1'h0, 3'h0, 3'h2, 1'h0);
    t_wake(1'h0, 1'h1, 1'h1, 3'h1, 3'h3, 1'h0);
    t_wake(1'h0, 1'h1, 1'h1, 3'h5, 3'h2, 1'h1);
    t_wake(1'h1, 1'h0, 1'h0, 3'h0, 3'h2, 1'h0);
    t_wake(1'h1, 1'h1, 1'h1, 3'h2, 3'h2, 1'h0);
    t_wake(1'h1, 1'h1, 1'h1, 3'h6, 3'h1, 1'h1);
    t_halt_gate();
    t_idle();
    t_resets();
    t_misc();
    t_pending();
    results();
  end
endmodule
